// ===== core/prlc_pkg.sv
// constants and types shared by the program ram load control block
package prlc_pkg;

  // ---------------------------------------------------------------
  // register offsets on the serial bus
  // ---------------------------------------------------------------
  localparam logic [7:0] PRLC_OFS_FW_REV   = 8'h41;
  localparam logic [7:0] PRLC_OFS_CTRL     = 8'h60;
  localparam logic [7:0] PRLC_OFS_DATA     = 8'h61;
  localparam logic [7:0] PRLC_OFS_START_LO = 8'h62;
  localparam logic [7:0] PRLC_OFS_START_HI = 8'h63;

  // ---------------------------------------------------------------
  // control register fields and values
  // ---------------------------------------------------------------
  localparam int PRLC_BIT_ACCESS_SEL = 7;
  localparam int PRLC_BIT_CORE_HOLD  = 6;
  localparam int PRLC_BIT_RSVD       = 5;
  localparam int PRLC_BIT_PARITY_CHECK_ENABLE     = 4;
  localparam int PRLC_BIT_RAM_EN     = 3;
  localparam int PRLC_BIT_PARITY_SPACE_SELECT    = 2;
  localparam int PRLC_BIT_DIR        = 1;
  localparam int PRLC_BIT_PTR_CLR    = 0;

  localparam logic [7:0] PRLC_CTRL_RESET   = 8'h00;
  localparam logic [7:0] PRLC_FW_REV_RESET = 8'h00;
  localparam logic [7:0] PRLC_FW_REV_BAD   = 8'hFF;
  localparam logic [7:0] PRLC_START_RESET  = 8'h00;
  localparam logic [7:0] PRLC_UNMAPPED_RD  = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int PRLC_CORE_CLK_KHZ     = 20000;
  localparam int PRLC_VALIDATE_TIME_US = 1000;
  localparam int PRLC_VALIDATE_CYCLES  = (PRLC_VALIDATE_TIME_US * PRLC_CORE_CLK_KHZ) / 1000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic memory_access_select;
    logic core_hold;
    logic reserved;
    logic parity_check_enable;
    logic ram_enable;
    logic parity_space_select;
    logic transfer_direction;
    logic pointer_clear;
  } prlc_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write;
  } prlc_req_t;

endpackage

// ===== core/prlc_sync.sv
// two flip-flop synchroniser for level or toggle signals
`timescale 1ns/1ps
module prlc_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta   <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// ===== core/prlc_top.sv
// program ram load control: serial-bus register port, program and parity memories
`timescale 1ns/1ps

// Contract
// R1: access select gates memory reads and writes
// R2: core hold keeps the cpu in reset
// R3: core hold never alters register contents
// R4: parity check enable turns on parity checking
// R5: host keeps parity checking on for ram
// R6: ram enable selects ram plus rom execution
// R7: host sets ram enable after loading
// R8: parity space select steers port to parity
// R9: direction selects data port write or read
// R10: back-to-back data bytes until stop condition
// R11: pointer clear resets the address pointer
// R12: host pulses pointer clear 0-1-0 first
// R13: control register fully read/write, resets zero
// R14: data port starts at start address
// R15: host setup sequence before a transfer
// R16: host run sequence after loading
// R17: validate within 1ms, flag invalid load; code starts validation only when ram enable is set with core hold clear
// R18: pointer advances one per data byte
module prlc_top
  import prlc_pkg::*;
#(
  parameter int         DEPTH           = 1024,
  parameter int         VALIDATE_CYCLES = PRLC_VALIDATE_CYCLES,
  parameter logic [7:0] FW_REV_VALID    = 8'h01 // arbitrary valid revision
)
(
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_link_clk,
  input  wire logic                     i_link_wr_stb,
  input  wire logic                     i_link_rd_stb,
  input  wire logic [7:0]               i_link_addr,
  input  wire logic [7:0]               i_link_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] i_cpu_fetch_addr,
  output logic      [7:0]               o_link_rdata,
  output logic                          o_link_busy,
  output logic                          o_cpu_hold,
  output logic                          o_exec_from_ram,
  output logic                          o_parity_check_en,
  output logic                          o_safe_mode,
  output logic      [7:0]               o_fetch_data,
  output logic                          o_parity_error
);

  localparam int AW = $clog2(DEPTH);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // pointer wraps at 2**AW, so a depth that is not a power of two would index past the array
  if (DEPTH < 2 || DEPTH > 65536 || DEPTH >= VALIDATE_CYCLES || (1 << AW) != DEPTH)
  begin : g_bad_param
    $error("prlc_top: DEPTH must be a power of two 2..65536 and below VALIDATE_CYCLES");
  end

  // ---------------------------------------------------------------
  // link domain: request capture and answer collection
  // ---------------------------------------------------------------
  typedef struct packed {
    prlc_req_t  req;
    logic       req_tgl;
    logic       busy;
    logic [7:0] rdata;
  } prlc_link_st_t;

  prlc_link_st_t lnk;
  prlc_link_st_t next_lnk;
  logic          ack_tgl_l;
  logic          core_ack_tgl;
  logic [7:0]    core_rd_data;

  prlc_sync #(.WIDTH(1)) u_ack_sync
  (
    .i_clk   (i_link_clk),
    .i_rst_b (i_rst_b),
    .i_async (core_ack_tgl),
    .o_sync  (ack_tgl_l)
  );

  // a new strobe is only taken once the previous answer came back
  always_comb
  begin
    next_lnk = lnk;
    if (lnk.busy && (ack_tgl_l == lnk.req_tgl))
    begin
      next_lnk.busy  = 1'b0;
      next_lnk.rdata = core_rd_data;
    end
    else if (!lnk.busy && (i_link_wr_stb || i_link_rd_stb))
    begin
      next_lnk.req.addr  = i_link_addr;
      next_lnk.req.wdata = i_link_wdata;
      next_lnk.req.write = i_link_wr_stb;
      next_lnk.req_tgl   = ~lnk.req_tgl;
      next_lnk.busy      = 1'b1;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      lnk <= '0;
    else
      lnk <= next_lnk;
  end

  assign o_link_busy  = lnk.busy;
  assign o_link_rdata = lnk.rdata;

  // ---------------------------------------------------------------
  // core domain: registers, pointer, validation
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {ST_IDLE, ST_SCAN} prlc_state_e;

  typedef struct packed {
    prlc_state_e state;
    prlc_ctrl_t  ctrl;
    logic [15:0] start;
    logic [7:0]  fw_rev;
    logic [AW-1:0] ptr;
    logic [AW-1:0] scan_idx;
    logic        scan_bad;
    logic [31:0] window;
    logic        safe_mode;
    logic        ack_tgl;
    logic [7:0]  rd_data;
    logic [7:0]  fetch_data;
    logic        parity_error;
  } prlc_core_st_t;

  prlc_core_st_t cs;
  prlc_core_st_t next_cs;
  logic          req_tgl_c;
  logic [7:0]    prog_mem [DEPTH];
  logic [7:0]    par_mem  [DEPTH];
  logic          mem_we;
  logic          par_we;
  logic [AW-1:0] mem_waddr;
  logic [7:0]    mem_wdata;

  prlc_sync #(.WIDTH(1)) u_req_sync
  (
    .i_clk   (i_core_clk),
    .i_rst_b (i_rst_b),
    .i_async (lnk.req_tgl),
    .o_sync  (req_tgl_c)
  );

  // request fields are held stable by the link side until the ack returns
  function automatic logic par_ok(input logic [7:0] data, input logic [7:0] par);
    par_ok = ((^data) == par[0]);
  endfunction

  always_comb
  begin
    next_cs   = cs;
    mem_we    = 1'b0;
    par_we    = 1'b0;
    mem_waddr = cs.ptr;
    mem_wdata = lnk.req.wdata;

    if (cs.ctrl.pointer_clear)
      next_cs.ptr = cs.start[AW-1:0]; // R11 R14

    if (req_tgl_c != cs.ack_tgl)
    begin
      next_cs.ack_tgl = req_tgl_c;
      next_cs.rd_data = PRLC_UNMAPPED_RD;
      case (lnk.req.addr)
        PRLC_OFS_CTRL:
        begin
          if (lnk.req.write)
          begin
            next_cs.ctrl = prlc_ctrl_t'(lnk.req.wdata); // R13
            if (lnk.req.wdata[PRLC_BIT_RAM_EN] && !cs.ctrl.ram_enable
                && !lnk.req.wdata[PRLC_BIT_CORE_HOLD])
            begin
              next_cs.state    = ST_SCAN; // R17
              next_cs.scan_idx = '0;
              next_cs.scan_bad = 1'b0;
              next_cs.window   = '0;
            end
          end
          next_cs.rd_data = cs.ctrl; // R13
        end
        PRLC_OFS_DATA:
        begin
          // blocked unless access select is set and pointer is released
          if (cs.ctrl.memory_access_select && !cs.ctrl.pointer_clear) // R1 R11
          begin
            if (lnk.req.write && !cs.ctrl.transfer_direction) // R9
            begin
              mem_we      = !cs.ctrl.parity_space_select; // R8
              par_we      = cs.ctrl.parity_space_select; // R8
              next_cs.ptr = cs.ptr + AW'(1); // R18 R10
            end
            else if (!lnk.req.write && cs.ctrl.transfer_direction) // R9
            begin
              next_cs.rd_data = cs.ctrl.parity_space_select ? par_mem[cs.ptr] : prog_mem[cs.ptr]; // R8
              next_cs.ptr     = cs.ptr + AW'(1); // R18 R10
            end
          end
        end
        PRLC_OFS_START_LO:
        begin
          if (lnk.req.write)
            next_cs.start[7:0] = lnk.req.wdata;
          next_cs.rd_data = cs.start[7:0];
        end
        PRLC_OFS_START_HI:
        begin
          if (lnk.req.write)
            next_cs.start[15:8] = lnk.req.wdata;
          next_cs.rd_data = cs.start[15:8];
        end
        PRLC_OFS_FW_REV:
          next_cs.rd_data = cs.fw_rev;
        default:
          next_cs.rd_data = PRLC_UNMAPPED_RD;
      endcase
    end

    // validation walks every location once, well inside the window
    case (cs.state)
      ST_IDLE:
        next_cs.window = '0;
      ST_SCAN:
      begin
        next_cs.window = cs.window + 32'd1;
        if (cs.ctrl.parity_check_enable && !par_ok(prog_mem[cs.scan_idx], par_mem[cs.scan_idx]))
          next_cs.scan_bad = 1'b1;
        next_cs.scan_idx = cs.scan_idx + AW'(1);
        if (cs.scan_idx == AW'(DEPTH - 1))
        begin
          next_cs.state = ST_IDLE;
          if (cs.scan_bad || (cs.ctrl.parity_check_enable
              && !par_ok(prog_mem[cs.scan_idx], par_mem[cs.scan_idx])))
          begin
            next_cs.fw_rev          = PRLC_FW_REV_BAD; // R17
            next_cs.ctrl.ram_enable = 1'b0; // R17
            next_cs.safe_mode       = 1'b1; // R17
          end
          else
          begin
            next_cs.fw_rev    = FW_REV_VALID;
            next_cs.safe_mode = 1'b0;
          end
        end
      end
      default:
        next_cs.state = ST_IDLE;
    endcase

    // cpu fetch path; hold stops the cpu and, if set in the same write as ram enable, blocks validation; registers stay as written
    next_cs.fetch_data   = (cs.ctrl.ram_enable && !cs.ctrl.core_hold) ? prog_mem[i_cpu_fetch_addr] : 8'h00; // R6 R3
    next_cs.parity_error = cs.ctrl.parity_check_enable && cs.ctrl.ram_enable && !cs.ctrl.core_hold
                           && !par_ok(prog_mem[i_cpu_fetch_addr], par_mem[i_cpu_fetch_addr]); // R4
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cs        <= '0;
      cs.state  <= ST_IDLE;
      cs.ctrl   <= PRLC_CTRL_RESET; // R13
      cs.fw_rev <= PRLC_FW_REV_RESET;
    end
    else
      cs <= next_cs;
  end

  // memories carry no reset; contents are loaded by the host
  always_ff @(posedge i_core_clk)
  begin
    if (mem_we)
      prog_mem[mem_waddr] <= mem_wdata;
    if (par_we)
      par_mem[mem_waddr] <= mem_wdata;
  end

  assign core_ack_tgl      = cs.ack_tgl;
  assign core_rd_data      = cs.rd_data;
  assign o_cpu_hold        = cs.ctrl.core_hold; // R2
  assign o_exec_from_ram   = cs.ctrl.ram_enable; // R6
  assign o_parity_check_en = cs.ctrl.parity_check_enable; // R4
  assign o_safe_mode       = cs.safe_mode;
  assign o_fetch_data      = cs.fetch_data;
  assign o_parity_error    = cs.parity_error;

endmodule

// ===== dv/prlc_props.sv
// assertion checker for the program ram load control block
`timescale 1ns/1ps
module prlc_props
#(
  parameter int DEPTH = 16
)
(
  input wire logic                     i_core_clk,
  input wire logic                     i_rst_b,
  input wire logic                     i_link_clk,
  input wire logic                     i_link_wr_stb,
  input wire logic                     i_link_rd_stb,
  input wire logic [7:0]               i_link_addr,
  input wire logic [7:0]               i_link_wdata,
  input wire logic [$clog2(DEPTH)-1:0] i_cpu_fetch_addr,
  input wire logic [7:0]               o_link_rdata,
  input wire logic                     o_link_busy,
  input wire logic                     o_cpu_hold,
  input wire logic                     o_exec_from_ram,
  input wire logic                     o_parity_check_en,
  input wire logic                     o_safe_mode,
  input wire logic [7:0]               o_fetch_data,
  input wire logic                     o_parity_error
);
  // three cycles tolerate the one-cycle register lag of the outputs
  a_hold_blanks_fetch: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_cpu_hold [*3] |-> o_fetch_data == 8'h00) else $error("fetch data while held");
  a_hold_no_parity: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_cpu_hold [*3] |-> !o_parity_error) else $error("parity error while held");
  a_rom_only_fetch: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !o_exec_from_ram [*3] |-> o_fetch_data == 8'h00) else $error("ram fetch while disabled");
  a_parity_off_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !o_parity_check_en [*3] |-> !o_parity_error) else $error("parity error while off");
  a_safe_drops_ram: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(o_safe_mode) |-> ##[0:3] !o_exec_from_ram) else $error("ram kept in safe mode");
  a_take_sets_busy: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    (i_link_wr_stb || i_link_rd_stb) && !o_link_busy |=> o_link_busy) else $error("request not taken");
  a_busy_bounded: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    $rose(o_link_busy) |-> ##[1:24] !o_link_busy) else $error("answer too late");
  a_busy_has_cause: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    $rose(o_link_busy) |-> $past(i_link_wr_stb) || $past(i_link_rd_stb)) else $error("busy without request");
  a_rdata_at_answer: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    $changed(o_link_rdata) |-> $fell(o_link_busy)) else $error("read data moved outside answer");
  c_ram_run: cover property (@(posedge i_core_clk) $rose(o_exec_from_ram));
  c_safe: cover property (@(posedge i_core_clk) $rose(o_safe_mode));
  c_answer: cover property (@(posedge i_link_clk) $fell(o_link_busy));
endmodule

bind prlc_top prlc_props #(.DEPTH(DEPTH)) prlc_props_i (.i_core_clk, .i_rst_b, .i_link_clk,
  .i_link_wr_stb, .i_link_rd_stb, .i_link_addr, .i_link_wdata, .i_cpu_fetch_addr, .o_link_rdata,
  .o_link_busy, .o_cpu_hold, .o_exec_from_ram, .o_parity_check_en, .o_safe_mode, .o_fetch_data,
  .o_parity_error);

// ===== dv/prlc_host.sv
// serial-bus host model on the link side of the block
`timescale 1ns/1ps
module prlc_host
(
  input  wire logic       i_link_clk,
  input  wire logic       i_busy,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_stb = 1'b0,
  output logic            o_rd_stb = 1'b0,
  output logic      [7:0] o_addr   = 8'h00,
  output logic      [7:0] o_wdata  = 8'h00
);
  int timeouts = 0;

  // one byte per request; stop has no pin, so each byte ends its own
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge i_link_clk);
    o_wr_stb <= w;
    o_rd_stb <= !w;
    o_addr   <= a;
    o_wdata  <= d;
    @(posedge i_link_clk);
    o_wr_stb <= 1'b0;
    o_rd_stb <= 1'b0;
    o_addr   <= ~a; // released lines never keep the last value
    o_wdata  <= ~d;
    n = 0;
    // look after the edge so busy and read data have settled
    do
    begin
      @(posedge i_link_clk);
      #1;
      n++;
    end
    while (i_busy && n < 40);
    if (i_busy)
      timeouts++;
    q = i_rdata;
  endtask
endmodule

// ===== dv/test_prlc_top.sv
// self-checking bench for the program ram load control block
`timescale 1ns/1ps
module test_prlc_top;
  import prlc_pkg::*;
  localparam int DEPTH = 16;
  localparam int VCYC  = 64;
  logic            i_core_clk = 1'b0;
  logic            i_link_clk = 1'b0;
  logic            i_rst_b    = 1'b0;
  logic      [3:0] fa         = 4'h0;
  wire logic       wr, rd, busy, hold, exec, pchk, safe, perr;
  wire logic [7:0] addr, wdata, rdata, fdata;
  int              bad_count  = 0;
  int              checks     = 0;
  int              cyc        = 0;
  logic      [7:0] q;

  prlc_top #(.DEPTH(DEPTH), .VALIDATE_CYCLES(VCYC), .FW_REV_VALID(8'h01)) prlc_top_i (
    .i_core_clk, .i_rst_b, .i_link_clk, .i_link_wr_stb(wr), .i_link_rd_stb(rd), .i_link_addr(addr),
    .i_link_wdata(wdata), .i_cpu_fetch_addr(fa), .o_link_rdata(rdata), .o_link_busy(busy),
    .o_cpu_hold(hold), .o_exec_from_ram(exec), .o_parity_check_en(pchk), .o_safe_mode(safe),
    .o_fetch_data(fdata), .o_parity_error(perr));
  prlc_host prlc_host_i (.i_link_clk, .i_busy(busy), .i_rdata(rdata), .o_wr_stb(wr),
    .o_rd_stb(rd), .o_addr(addr), .o_wdata(wdata));

  initial forever #25 i_core_clk = ~i_core_clk;
  initial
  begin
    #7;
    forever #15 i_link_clk = ~i_link_clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    bad_count += prlc_host_i.timeouts;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic w8(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    prlc_host_i.xfer(1'b1, a, d, r);
  endtask
  task automatic r8(input logic [7:0] a);
    prlc_host_i.xfer(1'b0, a, 8'h00, q);
  endtask
  // pointer clear pulsed low-high-low before each memory pass
  task automatic arm(input logic [7:0] c);
    w8(PRLC_OFS_CTRL, c);
    w8(PRLC_OFS_CTRL, c | 8'h01);
    w8(PRLC_OFS_CTRL, c);
  endtask
  function automatic logic [7:0] pat(input int i);
    return 8'h5A ^ 8'(i * 37);
  endfunction

  task automatic t_regs();
    r8(PRLC_OFS_CTRL); chk(q, 8'h00);
    w8(PRLC_OFS_START_LO, 8'h05);
    w8(PRLC_OFS_CTRL, 8'h60);
    chk({7'h00, hold}, 8'h01);
    r8(PRLC_OFS_CTRL); chk(q, 8'h60);
    w8(PRLC_OFS_CTRL, 8'h00);
    chk({7'h00, hold}, 8'h00);
    r8(PRLC_OFS_START_LO); chk(q, 8'h05);
    w8(PRLC_OFS_DATA, 8'hEE);
    r8(PRLC_OFS_DATA); chk(q, 8'h00);
    $display("regs test done");
  endtask

  task automatic t_load();
    w8(PRLC_OFS_START_LO, 8'h00);
    arm(8'hC0);
    for (int i = 0; i < DEPTH; i++) w8(PRLC_OFS_DATA, pat(i));
    arm(8'hC4);
    for (int i = 0; i < DEPTH; i++) w8(PRLC_OFS_DATA, {7'h00, ^pat(i)});
    w8(PRLC_OFS_START_LO, 8'h02);
    arm(8'hC2);
    for (int i = 2; i < 6; i++)
    begin
      r8(PRLC_OFS_DATA); chk(q, pat(i));
    end
    arm(8'hC6);
    r8(PRLC_OFS_DATA); chk(q, {7'h00, ^pat(2)});
    w8(PRLC_OFS_CTRL, 8'hC3);
    r8(PRLC_OFS_DATA); chk(q, 8'h00);
    $display("load test done");
  endtask

  task automatic t_run(input logic bad);
    if (bad)
    begin
      w8(PRLC_OFS_START_LO, 8'h05);
      arm(8'hC4);
      w8(PRLC_OFS_DATA, {7'h00, ~^pat(5)});
    end
    w8(PRLC_OFS_CTRL, 8'h18);
    chk({5'h00, hold, exec, pchk}, 8'h03);
    @(posedge i_core_clk) fa <= 4'h5;
    repeat (3) @(posedge i_core_clk);
    #1 chk(fdata, pat(5));
    chk({7'h00, perr}, {7'h00, bad});
    repeat (VCYC + 20) @(posedge i_core_clk);
    r8(PRLC_OFS_FW_REV); chk(q, bad ? PRLC_FW_REV_BAD : 8'h01);
    chk({6'h00, safe, exec}, bad ? 8'h02 : 8'h01);
    r8(PRLC_OFS_CTRL); chk(q, bad ? 8'h10 : 8'h18);
    $display("run test done");
  endtask

  // mid-run reset must drop every control bit and the safe state
  task automatic t_reset();
    @(posedge i_core_clk) i_rst_b <= 1'b0;
    repeat (12) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_link_clk);
    chk({6'h00, safe, exec}, 8'h00);
    r8(PRLC_OFS_CTRL); chk(q, 8'h00);
    $display("reset test done");
  endtask

  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      bad_count++;
      finish_test();
    end
  end

  initial
  begin
    repeat (12) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_link_clk);
    t_regs();
    t_load();
    t_run(1'b0);
    t_run(1'b1);
    t_reset();
    finish_test();
  end
endmodule
